// [design/scfg_dbg_route.v]
// Routes one core debug port between pads and register controls
`timescale 1ns/1ps
`default_nettype none
module scfg_dbg_route (
   input  wire i_attach,
   input  wire i_reg_clk,
   input  wire i_reg_di,
   input  wire i_pad_clk,
   input  wire i_pad_di,
   input  wire i_core_do,
   input  wire i_core_do_oe_n,
   output wire o_core_clk,
   output wire o_core_di,
   output wire o_pad_do,
   output wire o_pad_do_oe_n
);
   assign o_core_clk    = i_attach ? i_reg_clk : i_pad_clk;
   assign o_core_di     = i_attach ? i_reg_di  : i_pad_di;
   assign o_pad_do      = i_core_do;
   // Pad is released while attached to the registers so an external probe sees no drive
   assign o_pad_do_oe_n = i_attach ? 1'b1 : i_core_do_oe_n;
endmodule // scfg_dbg_route
`default_nettype wire

// [design/scfg_in_sync.v]
// Per-pin input synchroniser with bypass select
`timescale 1ns/1ps
`default_nettype none
module scfg_in_sync #(
   parameter W = 36
) (
   input  wire         i_clk,
   input  wire         i_reset,
   input  wire [W-1:0] i_pins,
   input  wire [W-1:0] i_bypass,
   output wire [W-1:0] o_pins
);
   reg [W-1:0] meta_reg;
   reg [W-1:0] sync_reg;

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         meta_reg <= {W{1'b0}};
         sync_reg <= {W{1'b0}};
      end else begin
         meta_reg <= i_pins;
         sync_reg <= meta_reg;
      end
   end

   assign o_pins = (i_bypass & i_pins) | (~i_bypass & sync_reg);
endmodule // scfg_in_sync
`default_nettype wire

// [design/scfg_regs.vh]
// Register map and reset values of the system configuration bank
`ifndef SCFG_REGS_VH
`define SCFG_REGS_VH

`define SCFG_OFF_NMI0        8'h00
`define SCFG_OFF_NMI1        8'h04
`define SCFG_OFF_CONFIG      8'h08
`define SCFG_OFF_BYP_LO      8'h0C
`define SCFG_OFF_BYP_HI      8'h10
`define SCFG_OFF_DBGF        8'h14
`define SCFG_OFF_MEMPD       8'h18

`define SCFG_NMI_RST         32'h00000000
`define SCFG_ID1_RST         4'h1
`define SCFG_ID0_RST         4'h0
`define SCFG_ID1_HI          31
`define SCFG_ID1_LO          28
`define SCFG_ID0_HI          27
`define SCFG_ID0_LO          24
`define SCFG_HALT1_BIT       1
`define SCFG_HALT0_BIT       0

`define SCFG_BYP_LO_W        30
`define SCFG_BYP_HI_W        6
`define SCFG_BYP_LO_RST      30'h00000000
`define SCFG_BYP_HI_RST      6'h00

`define SCFG_DBG_ATT1        7
`define SCFG_DBG_CLK1        6
`define SCFG_DBG_DI1         5
`define SCFG_DBG_DO1         4
`define SCFG_DBG_ATT0        3
`define SCFG_DBG_CLK0        2
`define SCFG_DBG_DI0         1
`define SCFG_DBG_DO0         0
`define SCFG_DBG_RST         8'h66
`define SCFG_DBG_RW_MASK     8'hEE

`define SCFG_MEMPD_W         8
`define SCFG_MEMPD_RST       8'h00

`define SCFG_SYNC_STAGES     2

`endif

// [design/scfg_top.v]
// System configuration register bank with APB slave
//
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "scfg_regs.vh"
module scfg_top #(
   parameter IRQ_W   = 32,
   parameter MEMPD_W = `SCFG_MEMPD_W
) (
   input  wire               i_clk,
   input  wire               i_reset,
   input  wire               i_psel,
   input  wire               i_penable,
   input  wire               i_pwrite,
   input  wire [7:0]         i_paddr,
   input  wire [31:0]        i_pwdata,
   input  wire [3:0]         i_pstrb,
   output reg  [31:0]        o_prdata,
   output wire               o_pready,
   output wire               o_pslverr,
   input  wire [IRQ_W-1:0]   i_irq,
   output reg                o_core0_nmi,
   output reg                o_core1_nmi,
   input  wire               i_core0_halted,
   input  wire               i_core1_halted,
   output wire [3:0]         o_core0_debug_instance_id,
   output wire [3:0]         o_core1_debug_instance_id,
   input  wire [35:0]        i_gpio_pins,
   output wire [35:0]        o_single_cycle_io_in,
   input  wire               i_pad0_clk,
   input  wire               i_pad0_di,
   output wire               o_pad0_do,
   output wire               o_pad0_do_oe_n,
   input  wire               i_core0_do,
   input  wire               i_core0_do_oe_n,
   output wire               o_core0_clk,
   output wire               o_core0_di,
   input  wire               i_pad1_clk,
   input  wire               i_pad1_di,
   output wire               o_pad1_do,
   output wire               o_pad1_do_oe_n,
   input  wire               i_core1_do,
   input  wire               i_core1_do_oe_n,
   output wire               o_core1_clk,
   output wire               o_core1_di,
   output wire [MEMPD_W-1:0] o_memory_power_down
);
   ////////////////////////////////////////////////////////////////////////
   reg  [31:0]                core0_nmi_source_mask_reg;
   reg  [31:0]                core1_nmi_source_mask_reg;
   reg  [3:0]                 core0_id_reg;
   reg  [3:0]                 core1_id_reg;
   reg  [`SCFG_BYP_LO_W-1:0]  byp_lo_reg;
   reg  [`SCFG_BYP_HI_W-1:0]  byp_hi_reg;
   reg  [7:0]                 dbg_reg;
   reg  [MEMPD_W-1:0]         mempd_reg;
   reg  [31:0]                rdata_next;
   reg                        hit_next;
   wire                       wr_en;
   wire                       rd_en;
   wire                       mapped;

   // Merge byte lanes of a write over the old word
   function [31:0] merge;
      input [31:0] old_v;
      input [31:0] new_v;
      input [3:0]  strb;
      integer      k;
      begin
         merge = old_v;
         for (k = 0; k < 4; k = k + 1) begin
            if (strb[k]) begin
               merge[k*8 +: 8] = new_v[k*8 +: 8];
            end
         end
      end
   endfunction

   function sel;
      input [7:0] addr;
      input [7:0] off;
      begin
         sel = (addr == off);
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // Zero wait-state slave; unmapped offsets answer with an error
   assign o_pready = 1'b1;
   assign wr_en    = i_psel & i_penable & i_pwrite & mapped;
   assign rd_en    = i_psel & ~i_penable & ~i_pwrite;
   assign mapped   = sel(i_paddr, `SCFG_OFF_NMI0) |
                     sel(i_paddr, `SCFG_OFF_NMI1) |
                     sel(i_paddr, `SCFG_OFF_CONFIG) |
                     sel(i_paddr, `SCFG_OFF_BYP_LO) |
                     sel(i_paddr, `SCFG_OFF_BYP_HI) |
                     sel(i_paddr, `SCFG_OFF_DBGF) |
                     sel(i_paddr, `SCFG_OFF_MEMPD);
   assign o_pslverr = i_psel & i_penable & ~mapped;

   // Lane-merged words, each sliced below to its own field
   reg [31:0] wcfg;
   reg [31:0] wdbg;
   reg [31:0] wbyl;
   reg [31:0] wbyh;
   reg [31:0] wmpd;
   always @* begin
      wcfg = merge({core1_id_reg, core0_id_reg, 24'h000000}, i_pwdata,
                   i_pstrb);
      wdbg = merge({24'h000000, dbg_reg}, i_pwdata, i_pstrb);
      wbyl = merge({2'b00, byp_lo_reg}, i_pwdata, i_pstrb);
      wbyh = merge({26'h0000000, byp_hi_reg}, i_pwdata, i_pstrb);
      wmpd = merge({{(32-MEMPD_W){1'b0}}, mempd_reg}, i_pwdata, i_pstrb);
   end

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         core0_nmi_source_mask_reg <= `SCFG_NMI_RST;
         core1_nmi_source_mask_reg <= `SCFG_NMI_RST;
         core1_id_reg <= `SCFG_ID1_RST;
         core0_id_reg <= `SCFG_ID0_RST;
         byp_lo_reg   <= `SCFG_BYP_LO_RST;
         byp_hi_reg   <= `SCFG_BYP_HI_RST;
         dbg_reg      <= `SCFG_DBG_RST;
         mempd_reg    <= `SCFG_MEMPD_RST;
      end else if (wr_en) begin
         if (sel(i_paddr, `SCFG_OFF_NMI0)) begin
            core0_nmi_source_mask_reg <=
               merge(core0_nmi_source_mask_reg, i_pwdata, i_pstrb);
         end
         if (sel(i_paddr, `SCFG_OFF_NMI1)) begin
            core1_nmi_source_mask_reg <=
               merge(core1_nmi_source_mask_reg, i_pwdata, i_pstrb);
         end
         if (sel(i_paddr, `SCFG_OFF_CONFIG)) begin
            core1_id_reg <= wcfg[`SCFG_ID1_HI:`SCFG_ID1_LO];
            core0_id_reg <= wcfg[`SCFG_ID0_HI:`SCFG_ID0_LO];
         end
         if (sel(i_paddr, `SCFG_OFF_BYP_LO)) begin
            byp_lo_reg <= wbyl[`SCFG_BYP_LO_W-1:0];
         end
         if (sel(i_paddr, `SCFG_OFF_BYP_HI)) begin
            byp_hi_reg <= wbyh[`SCFG_BYP_HI_W-1:0];
         end
         if (sel(i_paddr, `SCFG_OFF_DBGF)) begin
            dbg_reg <= wdbg[7:0] & `SCFG_DBG_RW_MASK;
         end
         if (sel(i_paddr, `SCFG_OFF_MEMPD)) begin
            mempd_reg <= wmpd[MEMPD_W-1:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data captured in setup so it is stable through the access phase
   always @* begin
      rdata_next = 32'h00000000;
      hit_next   = 1'b1;
      case (i_paddr)
         `SCFG_OFF_NMI0:   rdata_next = core0_nmi_source_mask_reg;
         `SCFG_OFF_NMI1:   rdata_next = core1_nmi_source_mask_reg;
         `SCFG_OFF_CONFIG: begin
            rdata_next[`SCFG_ID1_HI:`SCFG_ID1_LO] = core1_id_reg;
            rdata_next[`SCFG_ID0_HI:`SCFG_ID0_LO] = core0_id_reg;
            rdata_next[`SCFG_HALT1_BIT] = i_core1_halted;
            rdata_next[`SCFG_HALT0_BIT] = i_core0_halted;
         end
         `SCFG_OFF_BYP_LO: rdata_next[`SCFG_BYP_LO_W-1:0] = byp_lo_reg;
         `SCFG_OFF_BYP_HI: rdata_next[`SCFG_BYP_HI_W-1:0] = byp_hi_reg;
         `SCFG_OFF_DBGF: begin
            rdata_next[7:0] = dbg_reg;
            rdata_next[`SCFG_DBG_DO1] = i_core1_do;
            rdata_next[`SCFG_DBG_DO0] = i_core0_do;
         end
         `SCFG_OFF_MEMPD:  rdata_next[MEMPD_W-1:0] = mempd_reg;
         default:          hit_next = 1'b0;
      endcase
   end

   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_prdata <= 32'h00000000;
      end else if (rd_en) begin
         o_prdata <= hit_next ? rdata_next : 32'h00000000;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Registered so glitches on the request lines never reach a core
   always @(posedge i_clk or posedge i_reset) begin
      if (i_reset) begin
         o_core0_nmi <= 1'b0;
         o_core1_nmi <= 1'b0;
      end else begin
         o_core0_nmi <= |(i_irq & core0_nmi_source_mask_reg[IRQ_W-1:0]);
         o_core1_nmi <= |(i_irq & core1_nmi_source_mask_reg[IRQ_W-1:0]);
      end
   end

   assign o_core0_debug_instance_id = core0_id_reg;
   assign o_core1_debug_instance_id = core1_id_reg;
   assign o_memory_power_down       = mempd_reg;

   ////////////////////////////////////////////////////////////////////////
   // GPIO pin synchroniser bypass
   scfg_in_sync #(
      .W (36)
   ) u_sync (
      .i_clk    (i_clk),
      .i_reset  (i_reset),
      .i_pins   (i_gpio_pins),
      .i_bypass ({byp_hi_reg, byp_lo_reg}),
      .o_pins   (o_single_cycle_io_in)
   );

   scfg_dbg_route u_dbg0 (
      .i_attach       (dbg_reg[`SCFG_DBG_ATT0]),
      .i_reg_clk      (dbg_reg[`SCFG_DBG_CLK0]),
      .i_reg_di       (dbg_reg[`SCFG_DBG_DI0]),
      .i_pad_clk      (i_pad0_clk),
      .i_pad_di       (i_pad0_di),
      .i_core_do      (i_core0_do),
      .i_core_do_oe_n (i_core0_do_oe_n),
      .o_core_clk     (o_core0_clk),
      .o_core_di      (o_core0_di),
      .o_pad_do       (o_pad0_do),
      .o_pad_do_oe_n  (o_pad0_do_oe_n)
   );

   scfg_dbg_route u_dbg1 (
      .i_attach       (dbg_reg[`SCFG_DBG_ATT1]),
      .i_reg_clk      (dbg_reg[`SCFG_DBG_CLK1]),
      .i_reg_di       (dbg_reg[`SCFG_DBG_DI1]),
      .i_pad_clk      (i_pad1_clk),
      .i_pad_di       (i_pad1_di),
      .i_core_do      (i_core1_do),
      .i_core_do_oe_n (i_core1_do_oe_n),
      .o_core_clk     (o_core1_clk),
      .o_core_di      (o_core1_di),
      .o_pad_do       (o_pad1_do),
      .o_pad_do_oe_n  (o_pad1_do_oe_n)
   );
endmodule // scfg_top
`default_nettype wire

// [tb/scfg_chk.sv]
// Port-level assertions for the system configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "scfg_regs.vh"
module scfg_chk #(
   parameter IRQ_W   = 32,
   parameter MEMPD_W = 8
) (
   input wire logic               i_clk,
   input wire logic               i_reset,
   input wire logic               i_psel,
   input wire logic               i_penable,
   input wire logic               i_pwrite,
   input wire logic [7:0]         i_paddr,
   input wire logic [31:0]        i_pwdata,
   input wire logic [3:0]         i_pstrb,
   input wire logic [31:0]        o_prdata,
   input wire logic [IRQ_W-1:0]   i_irq,
   input wire logic               o_core0_nmi,
   input wire logic               o_core1_nmi,
   input wire logic               i_core0_halted,
   input wire logic               i_core1_halted,
   input wire logic [3:0]         o_core0_debug_instance_id,
   input wire logic [3:0]         o_core1_debug_instance_id,
   input wire logic               i_pad0_clk,
   input wire logic               i_pad0_di,
   input wire logic               o_pad0_do_oe_n,
   input wire logic               o_core0_clk,
   input wire logic               o_core0_di,
   input wire logic [MEMPD_W-1:0] o_memory_power_down
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_reset);
   logic wr_acc;
   logic rd_set;
   // Full-word writes only; lane merging is left to the bench
   assign wr_acc = i_psel & i_penable & i_pwrite & (i_pstrb == 4'hF);
   assign rd_set = i_psel & ~i_penable & ~i_pwrite;
   ////////////////////////////////////////////////////////////////////////
   property p_nmi0_idle; i_irq == '0 |=> !o_core0_nmi; endproperty
   a_nmi0_idle: assert property (p_nmi0_idle)
      else $error("nmi0 no cause");
   property p_nmi1_idle; i_irq == '0 |=> !o_core1_nmi; endproperty
   a_nmi1_idle: assert property (p_nmi1_idle)
      else $error("nmi1 no cause");
   property p_id_rst; $fell(i_reset) |-> o_core0_debug_instance_id == 4'h0
      && o_core1_debug_instance_id == 4'h1; endproperty
   a_id_rst: assert property (p_id_rst) else $error("id reset value");
   property p_pd_rst; $fell(i_reset) |-> o_memory_power_down == '0; endproperty
   a_pd_rst: assert property (p_pd_rst) else $error("pd reset value");
   property p_id_wr; wr_acc && i_paddr == `SCFG_OFF_CONFIG |=>
      o_core0_debug_instance_id == $past(i_pwdata[27:24]) &&
      o_core1_debug_instance_id == $past(i_pwdata[31:28]); endproperty
   a_id_wr: assert property (p_id_wr) else $error("id write");
   property p_pd_wr; wr_acc && i_paddr == `SCFG_OFF_MEMPD |=>
      o_memory_power_down == $past(i_pwdata[7:0]); endproperty
   a_pd_wr: assert property (p_pd_wr) else $error("pd write");
   property p_detach; wr_acc && i_paddr == `SCFG_OFF_DBGF && !i_pwdata[3]
      |=> o_core0_clk == i_pad0_clk && o_core0_di == i_pad0_di; endproperty
   a_detach: assert property (p_detach) else $error("pad route");
   property p_attach; wr_acc && i_paddr == `SCFG_OFF_DBGF && i_pwdata[3]
      |=> o_core0_clk == $past(i_pwdata[2]) && o_pad0_do_oe_n &&
      o_core0_di == $past(i_pwdata[1]); endproperty
   a_attach: assert property (p_attach) else $error("reg route");
   property p_halt_rd; rd_set && i_paddr == `SCFG_OFF_CONFIG |=>
      o_prdata[0] == $past(i_core0_halted) && o_prdata[23:2] == 22'h0 &&
      o_prdata[1] == $past(i_core1_halted); endproperty
   a_halt_rd: assert property (p_halt_rd) else $error("halt read");
   c_write: cover property (wr_acc);
   c_nmi: cover property ($rose(o_core0_nmi));
   c_attach: cover property ($rose(o_pad0_do_oe_n));
endmodule // scfg_chk
bind scfg_top scfg_chk #(.IRQ_W(IRQ_W), .MEMPD_W(MEMPD_W)) u_chk (
   .i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel),
   .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr),
   .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
   .i_irq(i_irq), .o_core0_nmi(o_core0_nmi), .o_core1_nmi(o_core1_nmi),
   .i_core0_halted(i_core0_halted), .i_core1_halted(i_core1_halted),
   .o_core0_debug_instance_id(o_core0_debug_instance_id),
   .o_core1_debug_instance_id(o_core1_debug_instance_id),
   .i_pad0_clk(i_pad0_clk), .i_pad0_di(i_pad0_di),
   .o_pad0_do_oe_n(o_pad0_do_oe_n), .o_core0_clk(o_core0_clk),
   .o_core0_di(o_core0_di), .o_memory_power_down(o_memory_power_down));
`default_nettype wire

// [tb/scfg_core_model.sv]
// Behavioural model of one core's halt and debug pins
`timescale 1ns/1ps
`default_nettype none
module scfg_core_model (
   input  wire logic i_clk,
   input  wire logic i_reset,
   input  wire logic i_halt_req,
   input  wire logic i_swd_di,
   output var  logic o_halted,
   output wire logic o_do,
   output wire logic o_do_oe_n
);
   // observable data out
   // Inverted echo, so a wrong route cannot read back by luck
   assign o_do      = ~i_swd_di;
   assign o_do_oe_n = 1'b0;
   always_ff @(posedge i_clk or posedge i_reset) begin
      if (i_reset)
         o_halted <= 1'b0;
      else
         o_halted <= i_halt_req;
   end
endmodule // scfg_core_model
`default_nettype wire

// [tb/scfg_top_tb.sv]
// Self-checking bench for the system configuration bank
`timescale 1ns/1ps
`default_nettype none
`include "scfg_regs.vh"
module scfg_top_tb;
   logic        clk, rst, psel, pen, pwr, nmi0, nmi1, pready, perr;
   logic [7:0]  paddr, mpd;
   logic [31:0] pwdata, prdata, irq, q;
   logic [35:0] pins, single_cycle_io;
   logic [3:0]  id0, id1, strb;
   logic        p0c, p0d, p1c, p1d, h0r, h1r, h0, h1, e;
   logic        pdo0, poe0, pdo1, poe1, cdo0, coe0, cdo1, coe1;
   logic        cclk0, cdi0, cclk1, cdi1;
   int          error_cnt, n_compared;
   scfg_top uut (.i_clk(clk), .i_reset(rst), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata),
      .i_pstrb(strb), .o_prdata(prdata), .o_pready(pready),
      .o_pslverr(perr), .i_irq(irq), .o_core0_nmi(nmi0),
      .o_core1_nmi(nmi1), .i_core0_halted(h0), .i_core1_halted(h1),
      .o_core0_debug_instance_id(id0), .o_core1_debug_instance_id(id1),
      .i_gpio_pins(pins), .o_single_cycle_io_in(single_cycle_io), .i_pad0_clk(p0c),
      .i_pad0_di(p0d), .o_pad0_do(pdo0), .o_pad0_do_oe_n(poe0),
      .i_core0_do(cdo0), .i_core0_do_oe_n(coe0), .o_core0_clk(cclk0),
      .o_core0_di(cdi0), .i_pad1_clk(p1c), .i_pad1_di(p1d),
      .o_pad1_do(pdo1), .o_pad1_do_oe_n(poe1), .i_core1_do(cdo1),
      .i_core1_do_oe_n(coe1), .o_core1_clk(cclk1), .o_core1_di(cdi1),
      .o_memory_power_down(mpd));
   scfg_core_model u_c0 (.i_clk(clk), .i_reset(rst), .i_halt_req(h0r),
      .i_swd_di(cdi0), .o_halted(h0), .o_do(cdo0), .o_do_oe_n(coe0));
   scfg_core_model u_c1 (.i_clk(clk), .i_reset(rst), .i_halt_req(h1r),
      .i_swd_di(cdi1), .o_halted(h1), .o_do(cdo1), .o_do_oe_n(coe1));
   ////////////////////////////////////////////////////////////////////////
   task chk(input string nm, input logic [35:0] x, input logic [35:0] g);
      n_compared++;
      if (g !== x) begin
         error_cnt++;
         $display("[ERR] %s exp %h got %h", nm, x, g);
      end
   endtask
   // Master holds the request until pready is seen high
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwr <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      pen <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 100);
      if (n >= 100) chk("pready", 1, 0);
      q = prdata;
      e = perr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk("prdata", x, q);
   endtask
   task final_report;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(`SCFG_OFF_NMI0, 32'h0);
      rd(`SCFG_OFF_NMI1, 32'h0);
      rd(`SCFG_OFF_CONFIG, 32'h10000000);
      rd(`SCFG_OFF_BYP_LO, 32'h0);
      rd(`SCFG_OFF_BYP_HI, 32'h0);
      rd(`SCFG_OFF_DBGF, 32'h66);
      rd(`SCFG_OFF_MEMPD, 32'h0);
      $display("t_reset done");
   endtask
   task t_regs;
      h0r <= 1'b1;
      apb(1, `SCFG_OFF_NMI0, 32'hFFFFFFFF);
      apb(1, `SCFG_OFF_NMI1, 32'h5A5AA5A5);
      rd(`SCFG_OFF_NMI0, 32'hFFFFFFFF);
      rd(`SCFG_OFF_NMI1, 32'h5A5AA5A5);
      apb(1, `SCFG_OFF_CONFIG, 32'hE3FFFFFF);
      rd(`SCFG_OFF_CONFIG, 32'hE3000001);
      chk("id0", 4'h3, id0);
      chk("id1", 4'hE, id1);
      apb(1, `SCFG_OFF_CONFIG, 32'h10000000);
      h0r <= 1'b0;
      apb(1, `SCFG_OFF_MEMPD, 32'hFFFFFFA5);
      @(negedge clk);
      chk("mpd", 8'hA5, mpd);
      chk("pslverr0", 0, e);
      apb(1, 8'h1C, 32'hFFFFFFFF);
      chk("pslverr", 1, e);
      rd(8'h1C, 32'h0);
      apb(1, `SCFG_OFF_MEMPD, 32'h0);
      rd(`SCFG_OFF_NMI1, 32'h5A5AA5A5);
      // Single lane write leaves the other bytes alone
      strb <= 4'h2;
      apb(1, `SCFG_OFF_NMI1, 32'h0000C300);
      strb <= 4'hF;
      rd(`SCFG_OFF_NMI1, 32'h5A5AC3A5);
      $display("t_regs done");
   endtask
   task t_nmi;
      apb(1, `SCFG_OFF_NMI0, 32'h00000100);
      apb(1, `SCFG_OFF_NMI1, 32'h00000001);
      for (int i = 0; i < 3; i++) begin
         @(posedge clk);
         irq <= (i == 0) ? 32'h100 : (i == 1) ? 32'h1 : 32'hFFFFFEFE;
         // One register stage between request line and core
         @(posedge clk);
         @(negedge clk);
         chk("nmi0", i == 0, nmi0);
         chk("nmi1", i == 1, nmi1);
      end
      @(posedge clk);
      irq <= 32'h0;
      $display("t_nmi done");
   endtask
   task t_sync;
      apb(1, `SCFG_OFF_BYP_LO, 32'hFFFFFFFF);
      rd(`SCFG_OFF_BYP_LO, 32'h3FFFFFFF);
      apb(1, `SCFG_OFF_BYP_LO, 32'h00000001);
      apb(1, `SCFG_OFF_BYP_HI, 32'h00000021);
      @(posedge clk);
      pins <= 36'hFFFFFFFFF;
      @(negedge clk);
      chk("sio0", 36'h840000001, single_cycle_io);
      @(negedge clk);
      chk("sio1", 36'h840000001, single_cycle_io);
      @(negedge clk);
      chk("sio2", 36'hFFFFFFFFF, single_cycle_io);
      apb(1, `SCFG_OFF_BYP_LO, 32'h0);
      apb(1, `SCFG_OFF_BYP_HI, 32'h0);
      pins <= 36'h0;
      $display("t_sync done");
   endtask
   task t_dbg;
      apb(1, `SCFG_OFF_DBGF, 32'h0000006C);
      p1c <= 1'b1;
      @(negedge clk);
      chk("route0", 3'b101, {cclk0, cdi0, poe0});
      chk("route1", 2'b11, {cclk1, cdi1});
      chk("pdo", 3'b100, {pdo0, pdo1, poe1});
      rd(`SCFG_OFF_DBGF, 32'h6D);
      apb(1, `SCFG_OFF_DBGF, 32'h00000088);
      @(negedge clk);
      chk("route1a", 4'b0011, {cclk1, cdi1, poe1, pdo1});
      rd(`SCFG_OFF_DBGF, 32'h99);
      apb(1, `SCFG_OFF_DBGF, 32'h00000066);
      @(negedge clk);
      chk("pads0", 3'b010, {cclk0, cdi0, poe0});
      chk("pads1", 3'b110, {cclk1, cdi1, poe1});
      $display("t_dbg done");
   endtask
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   initial begin
      #100000;
      error_cnt++;
      final_report;
   end
   initial begin
      {rst, psel, pen, pwr, paddr, pwdata, irq, pins} = '1;
      {psel, pen, pwr, paddr, pwdata, irq, pins, p0c, p1c} = '0;
      {p0d, p1d, h0r, h1r} = 4'b1100;
      strb = 4'hF;
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_reset;
      t_regs;
      t_nmi;
      t_sync;
      t_dbg;
      final_report;
   end
endmodule // scfg_top_tb
`default_nettype wire
